// ===== common/sarc_pkg.sv
// shared constants for the conversion control block
package sarc_pkg;

    // clock rate
    localparam int unsigned CLK_KHZ        = 10_000;

    // conversion timing, longest time rounds down
    localparam int unsigned CONV_MAX_NS    = 427;
    localparam int unsigned CONV_CYC_RAW   = (CONV_MAX_NS * CLK_KHZ) / 1_000_000;
    localparam int unsigned CONV_CYC       = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;

    // window after start in which start may still toggle, longest time rounds down
    localparam int unsigned CNV_WIN_NS     = 40;
    localparam int unsigned CNV_WIN_RAW    = (CNV_WIN_NS * CLK_KHZ) / 1_000_000;
    localparam int unsigned CNV_WIN_CYC    = (CNV_WIN_RAW < 1) ? 1 : CNV_WIN_RAW;

    // least acquisition time, rounds up
    localparam int unsigned ACQ_MIN_NS     = 185;
    localparam int unsigned ACQ_CYC_RAW    = (ACQ_MIN_NS * CLK_KHZ + 999_999) / 1_000_000;
    localparam int unsigned ACQ_CYC        = (ACQ_CYC_RAW < 1) ? 1 : ACQ_CYC_RAW;

    // settling after power-on reset
    localparam int unsigned POR_WAIT_MS    = 100;
    localparam int unsigned POR_WAIT_CYC   = POR_WAIT_MS * CLK_KHZ;

    // wake-up wait after sleep; value not given, plain default
    localparam int unsigned WAKE_WAIT_MS   = 10;
    localparam int unsigned WAKE_WAIT_CYC  = WAKE_WAIT_MS * CLK_KHZ;

    // timer width, wide enough for the longest wait
    localparam int unsigned TMR_W          = 24;

    // small counters
    localparam int unsigned AGE_W          = 4;

    // control states
    typedef enum logic [3:0] {
        ST_NAP   = 4'b0001,
        ST_CONV  = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_WAKE  = 4'b1000
    } sarc_state_t;

endpackage

// ===== common/sarc_tmr_if.sv
// handshake between the controller and a down-counting timer
`timescale 1ns/1ps
interface sarc_tmr_if #(
    parameter int unsigned W = 24
);
    logic         start;
    logic [W-1:0] load;
    logic         done;
    logic         running;

    modport ctl (output start, output load, input done, input running);
    modport tmr (input start, input load, output done, output running);
endinterface

// ===== src/sarc_timer.sv
// down-counting timer: done pulses load cycles after the start cycle
`timescale 1ns/1ps
module sarc_timer #(
    parameter int unsigned W = 24
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    sarc_tmr_if.tmr   tmr
);
    logic [W-1:0] count;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count       <= '0;
            tmr.running <= 1'b0;
            tmr.done    <= 1'b0;
        end else begin
            tmr.done <= 1'b0;
            if (tmr.start) begin
                // a restart while running reloads; a zero load behaves as one
                count       <= (tmr.load == '0) ? W'(1) : tmr.load;
                tmr.running <= 1'b1;
            end else if (tmr.running) begin
                if (count == W'(1)) begin
                    tmr.running <= 1'b0;
                    tmr.done    <= 1'b1;
                end
                count <= count - W'(1);
            end
        end
    end
endmodule

// ===== src/sarc_ctrl.sv
// conversion start, busy, nap, sleep and power-on settling control
`timescale 1ns/1ps

// Functional notes
// R1: rising edge of start input begins a conversion and powers the core up.
// R2: start edges during a conversion are ignored; the conversion completes first.
// R3: busy stays high for the whole conversion.
// R4: host toggles start only within 40ns of start or after completion.
// R5: at conversion end the core powers down and tracks the input.
// R6: a new conversion is accepted even if readout was not finished.
// R7: conversion timed internally and finished within 427ns of start.
// R8: host leaves at least 185ns acquisition between conversions.
// R9: reset at power-up and on supply below 2V; reinitialise on return.
// R10: host waits 100ms after power-on reset; earlier results are invalid.
// R11: while napping, everything but the core stays active for readout.
// R12: two starts without serial clock rise: sleep at last busy fall.
// R13: serial clock rise wakes from sleep; host waits wake-up interval.
// R14: busy low when idle and after reset, falls when results are ready.
module sarc_ctrl #(
    parameter int unsigned POR_CYC  = sarc_pkg::POR_WAIT_CYC,
    parameter int unsigned WAKE_CYC = sarc_pkg::WAKE_WAIT_CYC
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic supply_ok,
    input  wire logic conversion_start_input,
    input  wire logic serial_clock,
    output logic      busy,
    output logic      core_power,
    output logic      acquiring,
    output logic      sleeping,
    output logic      settled,
    output logic      result_ready,
    output logic      result_invalid
);
    localparam int unsigned W = sarc_pkg::TMR_W;

    sarc_pkg::sarc_state_t state;
    sarc_pkg::sarc_state_t next_state;

    logic                           start_q;
    logic                           sck_q;
    logic                           start_rise;
    logic                           start_edge;
    logic                           sck_rise;
    logic                           accept;
    logic                           por_pending;
    logic [1:0]                     start_run;
    logic [sarc_pkg::AGE_W-1:0]     conv_age;
    logic [sarc_pkg::AGE_W-1:0]     acq_age;

    sarc_tmr_if #(.W(W)) conv_tmr ();
    sarc_tmr_if #(.W(W)) settle_tmr ();

    sarc_timer #(.W(W)) u_conv_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tmr     (conv_tmr)
    );

    sarc_timer #(.W(W)) u_settle_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tmr     (settle_tmr)
    );

    // edge detection on the synchronous pins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            start_q <= 1'b0;
            sck_q   <= 1'b0;
        end else begin
            start_q <= conversion_start_input;
            sck_q   <= serial_clock;
        end
    end

    assign start_rise = conversion_start_input & ~start_q;
    assign start_edge = conversion_start_input ^ start_q;
    assign sck_rise   = serial_clock & ~sck_q;

    // starts are taken in nap or during wake-up; a start during wake-up is marked invalid
    assign accept = supply_ok & start_rise & ((state == sarc_pkg::ST_NAP) | (state == sarc_pkg::ST_WAKE)); // R1 R2 R6

    // conversion timed by the internal counter, no external clock needed
    assign conv_tmr.start = accept; // R7
    // busy falls one cycle after done, so the timer runs one cycle short of the busy length
    assign conv_tmr.load  = W'(sarc_pkg::CONV_CYC - 1); // R7

    // power-on settling and wake-up share one timer; the pending power event wins
    assign settle_tmr.start = por_pending | (supply_ok & (state == sarc_pkg::ST_SLEEP) & sck_rise); // R9 R13
    assign settle_tmr.load  = por_pending ? W'(POR_CYC) : W'(WAKE_CYC); // R10 R13

    // a supply drop restarts settling on every cycle until the supply returns
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            por_pending <= 1'b1; // R9
        end else begin
            por_pending <= ~supply_ok; // R9
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            sarc_pkg::ST_NAP: begin
                if (accept) begin
                    next_state = sarc_pkg::ST_CONV; // R1
                end
            end
            sarc_pkg::ST_CONV: begin
                // further start edges are not looked at here
                if (conv_tmr.done) begin
                    next_state = (start_run == 2'd2) ? sarc_pkg::ST_SLEEP : sarc_pkg::ST_NAP; // R12 R5
                end
            end
            sarc_pkg::ST_SLEEP: begin
                if (sck_rise) begin
                    next_state = sarc_pkg::ST_WAKE; // R13
                end
            end
            sarc_pkg::ST_WAKE: begin
                if (accept) begin
                    next_state = sarc_pkg::ST_CONV;
                end else if (settle_tmr.done) begin
                    next_state = sarc_pkg::ST_NAP;
                end
            end
            default: begin
                next_state = sarc_pkg::ST_NAP;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= sarc_pkg::ST_NAP; // R14
        end else if (!supply_ok) begin
            state <= sarc_pkg::ST_NAP; // R9
        end else begin
            state <= next_state;
        end
    end

    // starts since the last serial clock rise; a clock rise in the same cycle as a start leaves one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            start_run <= 2'd0;
        end else if (!supply_ok || state == sarc_pkg::ST_SLEEP) begin
            start_run <= 2'd0;
        end else if (accept) begin
            start_run <= (sck_rise || start_run == 2'd0) ? 2'd1 : 2'd2; // R12
        end else if (sck_rise) begin
            start_run <= 2'd0; // R12
        end
    end

    // cycles since the conversion began, saturating
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            conv_age <= '0;
        end else if (accept) begin
            conv_age <= '0;
        end else if (conv_age != '1) begin
            conv_age <= conv_age + sarc_pkg::AGE_W'(1);
        end
    end

    // acquisition length since busy fell, saturating; full after reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acq_age <= '1;
        end else if (conv_tmr.done) begin
            acq_age <= '0;
        end else if (acq_age != '1) begin
            acq_age <= acq_age + sarc_pkg::AGE_W'(1);
        end
    end

    // busy follows the conversion exactly; the supply dropping aborts it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0; // R14
        end else if (!supply_ok) begin
            busy <= 1'b0; // R14
        end else if (accept) begin
            busy <= 1'b1; // R3
        end else if (conv_tmr.done) begin
            busy <= 1'b0; // R3 R14
        end
    end

    // core powered only while converting; nap and sleep keep it off
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            core_power <= 1'b0;
        end else if (!supply_ok) begin
            core_power <= 1'b0;
        end else if (accept) begin
            core_power <= 1'b1; // R1
        end else if (conv_tmr.done) begin
            core_power <= 1'b0; // R5
        end
    end

    // tracking the input in nap; the serial side stays alive there
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acquiring <= 1'b0;
            sleeping  <= 1'b0;
        end else begin
            acquiring <= supply_ok & (next_state == sarc_pkg::ST_NAP); // R5 R11
            sleeping  <= supply_ok & (next_state == sarc_pkg::ST_SLEEP); // R12
        end
    end

    // settled once the power-on or wake-up wait has run out
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            settled <= 1'b0; // R10
        end else if (settle_tmr.start || !supply_ok) begin
            settled <= 1'b0; // R10 R13
        end else if (state == sarc_pkg::ST_SLEEP && next_state == sarc_pkg::ST_SLEEP) begin
            settled <= 1'b0;
        end else if (settle_tmr.done) begin
            settled <= 1'b1; // R10 R13
        end
    end

    // results are ready in the cycle busy falls
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result_ready <= 1'b0;
        end else begin
            result_ready <= supply_ok & conv_tmr.done; // R14
        end
    end

    // a result is marked invalid when the host broke its own timing;
    // the device cannot stop that, it can only report it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result_invalid <= 1'b0;
        end else if (accept) begin
            result_invalid <= ~settled | (state == sarc_pkg::ST_WAKE)
                              | (acq_age < sarc_pkg::AGE_W'(sarc_pkg::ACQ_CYC)); // R8 R10 R13
        end else if (busy && start_edge && conv_age >= sarc_pkg::AGE_W'(sarc_pkg::CNV_WIN_CYC)) begin
            result_invalid <= 1'b1; // R4
        end else if (!supply_ok) begin
            result_invalid <= 1'b1; // R9
        end
    end
endmodule

// ===== dv/sarc_ctrl_props.sv
// property checker for the conversion control block
`timescale 1ns/1ps
module sarc_ctrl_props #(
    parameter int unsigned WAKE_CYC = sarc_pkg::WAKE_WAIT_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic supply_ok,
    input wire logic conversion_start_input,
    input wire logic serial_clock,
    input wire logic busy,
    input wire logic core_power,
    input wire logic acquiring,
    input wire logic sleeping,
    input wire logic settled,
    input wire logic result_ready,
    input wire logic result_invalid
);
    logic [23:0] wake_age;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // counts the wake wait; a ranged delay cannot cover the full-size wake count
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wake_age <= '0;
        end else if (!supply_ok || sleeping || settled) begin
            wake_age <= '0;
        end else if ($fell(sleeping) || wake_age != '0) begin
            wake_age <= wake_age + 24'h1;
        end
    end

    sequence s_take;
        $rose(conversion_start_input) && !busy && !sleeping && supply_ok;
    endsequence

    AST_START: assert property (s_take |=> busy && core_power && !acquiring)
        else $error("start not taken");
    AST_BUSY_LEN: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
        else $error("busy length wrong");
    AST_NO_RESTART: assert property ($rose(busy) ##2 $rose(conversion_start_input) |-> ##2 !busy)
        else $error("conversion restarted");
    AST_READY: assert property ($fell(busy) && $past(supply_ok) |-> result_ready && !core_power)
        else $error("no result at busy fall");
    AST_ACQ: assert property ($fell(busy) && !sleeping && $past(supply_ok) |-> acquiring)
        else $error("not acquiring after conversion");
    AST_SLEEP_ENTRY: assert property ($rose(sleeping) |-> $fell(busy))
        else $error("sleep entered off busy fall");
    AST_WAKE: assert property (sleeping && $rose(serial_clock) |=> !sleeping && !settled)
        else $error("no wake on serial clock");
    AST_WAKE_TIME: assert property (wake_age <= WAKE_CYC + 3)
        else $error("wake wait too long");
    AST_POR: assert property (!$past(resetn) |-> !busy && !settled && !result_ready)
        else $error("outputs active after reset");
    AST_SUPPLY: assert property (!supply_ok |=> !busy && !settled && result_invalid)
        else $error("low supply not handled");
    AST_EARLY: assert property (s_take and !settled |=> result_invalid)
        else $error("early result not flagged");
    AST_SLEEP_IGNORE: assert property (sleeping && $rose(conversion_start_input) |=> !busy)
        else $error("start taken in sleep");

    cover property (s_take);
    cover property ($rose(sleeping));
    cover property ($rose(settled));
endmodule

bind sarc_ctrl sarc_ctrl_props #(.WAKE_CYC(WAKE_CYC)) u_props (
    .sys_clk(sys_clk), .resetn(resetn), .supply_ok(supply_ok),
    .conversion_start_input(conversion_start_input), .serial_clock(serial_clock),
    .busy(busy), .core_power(core_power), .acquiring(acquiring), .sleeping(sleeping),
    .settled(settled), .result_ready(result_ready), .result_invalid(result_invalid)
);

// ===== dv/sarc_host_model.sv
// host side model: drives conversion start and serial clock
`timescale 1ns/1ps
module sarc_host_model (
    input  wire logic sys_clk,
    output logic      conversion_start_input,
    output logic      serial_clock
);
    initial begin
        conversion_start_input = 1'b0;
        serial_clock           = 1'b0;
    end

    // one edge per call, so the caller keeps count of cycles
    task automatic set_start(input logic v);
        @(posedge sys_clk);
        conversion_start_input <= v;
    endtask

    // serial clock stays low outside readout; callers pulse it only while idle
    task automatic sck_pulse();
        @(posedge sys_clk);
        serial_clock <= 1'b1;
        @(posedge sys_clk);
        serial_clock <= 1'b0;
    endtask

    // slow host: leaves extra acquisition time before the next start
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
endmodule

// ===== dv/sarc_ctrl_test.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module sarc_ctrl_test;
    localparam int unsigned POR  = 20;
    localparam int unsigned WAKE = 10;
    logic sys_clk;
    logic resetn;
    logic supply_ok;
    logic conversion_start_input;
    logic serial_clock;
    logic busy;
    logic core_power;
    logic acquiring;
    logic sleeping;
    logic settled;
    logic result_ready;
    logic result_invalid;
    int   bad_count;
    int   n_compared;
    int   len;

    sarc_ctrl #(.POR_CYC(POR), .WAKE_CYC(WAKE)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .supply_ok(supply_ok),
        .conversion_start_input(conversion_start_input), .serial_clock(serial_clock),
        .busy(busy), .core_power(core_power), .acquiring(acquiring), .sleeping(sleeping),
        .settled(settled), .result_ready(result_ready), .result_invalid(result_invalid)
    );
    sarc_host_model host (
        .sys_clk(sys_clk), .conversion_start_input(conversion_start_input),
        .serial_clock(serial_clock)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask

    task automatic check_len(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            bad_count++;
            $display("ERROR %0t busy lasted %0d", $time, got);
        end
    endtask

    // sample 1 ns after the edge so that edge's updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_settled(input int lim);
        int k;
        k = 0;
        while (settled !== 1'b1 && k < lim) begin
            tick(1);
            k++;
        end
        check_bit(settled, 1'b1, "not settled");
    endtask

    // tog > 0 raises start again that many busy cycles in, past the short window
    task automatic run_conv(input int tog, input logic inv, input logic slp);
        host.set_start(1'b1);
        host.set_start(1'b0);
        // busy rises on the edge that takes the start; look before the next one so no cycle is missed
        #1;
        check_bit(busy, 1'b1, "busy low");
        check_bit(core_power, 1'b1, "core off");
        len = 0;
        while (busy === 1'b1 && len < 8) begin
            len++;
            if (len == tog) begin
                host.set_start(1'b1);
            end else begin
                @(posedge sys_clk);
            end
            #1;
        end
        check_len(len, sarc_pkg::CONV_CYC);
        check_bit(result_ready, 1'b1, "no result");
        check_bit(core_power, 1'b0, "core on");
        check_bit(acquiring, !slp, "acquire");
        check_bit(sleeping, slp, "sleep");
        check_bit(result_invalid, inv, "validity");
        host.set_start(1'b0);
    endtask

    task automatic t_por();
        tick(1);
        check_bit(busy, 1'b0, "busy after reset");
        check_bit(settled, 1'b0, "settled early");
        run_conv(0, 1'b1, 1'b0);
        wait_settled(POR + 10);
    endtask

    task automatic t_conv();
        host.sck_pulse();
        run_conv(0, 1'b0, 1'b0);
        host.idle(sarc_pkg::ACQ_CYC);
        host.sck_pulse();
        run_conv(0, 1'b0, 1'b0);
        host.sck_pulse();
        run_conv(2, 1'b1, 1'b0);
    endtask

    task automatic t_sleep();
        host.sck_pulse();
        run_conv(0, 1'b0, 1'b0);
        run_conv(0, 1'b0, 1'b1);
        host.set_start(1'b1);
        host.set_start(1'b0);
        tick(2);
        check_bit(busy, 1'b0, "start in sleep");
        check_bit(sleeping, 1'b1, "left sleep");
        host.sck_pulse();
        tick(1);
        check_bit(sleeping, 1'b0, "no wake");
        check_bit(settled, 1'b0, "no wake wait");
        wait_settled(WAKE + 5);
        check_bit(acquiring, 1'b1, "not tracking");
    endtask

    task automatic t_supply();
        @(posedge sys_clk);
        supply_ok <= 1'b0;
        tick(2);
        check_bit(busy, 1'b0, "busy in brownout");
        check_bit(settled, 1'b0, "settled in brownout");
        check_bit(result_invalid, 1'b1, "brownout result");
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        wait_settled(POR + 10);
        host.sck_pulse();
        run_conv(0, 1'b0, 1'b0);
    endtask

    // reset in mid-conversion: the conversion is dropped and settling starts over
    task automatic t_reset();
        host.sck_pulse();
        host.set_start(1'b1);
        host.set_start(1'b0);
        tick(1);
        check_bit(busy, 1'b1, "busy low before reset");
        @(posedge sys_clk);
        resetn <= 1'b0;
        tick(2);
        check_bit(busy, 1'b0, "busy in reset");
        check_bit(core_power, 1'b0, "core on in reset");
        @(posedge sys_clk);
        resetn <= 1'b1;
        tick(1);
        check_bit(busy, 1'b0, "busy after mid reset");
        check_bit(settled, 1'b0, "settled after mid reset");
        check_bit(result_ready, 1'b0, "result after mid reset");
        wait_settled(POR + 10);
        host.sck_pulse();
        run_conv(0, 1'b0, 1'b0);
    endtask

    initial begin
        resetn     = 1'b0;
        supply_ok  = 1'b1;
        bad_count  = 0;
        n_compared = 0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        t_por();
        t_conv();
        t_sleep();
        t_supply();
        t_reset();
        finish_test();
    end

    // whole run needs under two hundred cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end
endmodule
